// ==== hw/fpmsu_core.sv ====
// Floating multiply-and-split datapath with AXI4-Lite control registers.
// Assumes one clock and software polling the busy bit before a new command.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
module fpmsu_core (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             trapReq,
	output logic      [1:0]  trapCause
);
	// ********************************************************
	// Helper functions
	// ********************************************************
	function automatic logic isMapped(input logic [7:0] a);
		if (a == fpmsu_pkg::REG_CMD || a == fpmsu_pkg::REG_FSTAT) return 1'b1;
		else if (a == fpmsu_pkg::REG_SRCLO || a == fpmsu_pkg::REG_SRCHI) return 1'b1;
		else if (a == fpmsu_pkg::REG_FLAGS || a == fpmsu_pkg::REG_FRACLO) return 1'b1;
		else if (a == fpmsu_pkg::REG_FRACHI || a == fpmsu_pkg::REG_INTLO) return 1'b1;
		else if (a == fpmsu_pkg::REG_INTHI) return 1'b1;
		else return 1'b0;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic [63:0] packF(input logic s, input logic [7:0] e,
		input logic [55:0] m);
		return {s, e, m[54:0]};
	endfunction

	// Top L bits of the product window
	function automatic logic [55:0] chopM(input logic [63:0] w, input logic dbl);
		return dbl ? w[63:8] : {w[63:40], 32'h0};
	endfunction

	// Round or chop to L bits; a carry out gives the next power of two
	function automatic logic [63:0] packR(input logic s, input logic [7:0] e,
		input logic [63:0] w, input logic dbl, input logic chop);
		logic [56:0] t;
		logic        g;
		g = dbl ? w[7] : w[39];
		t = {1'b0, chopM(w, dbl)} + ((chop || !g) ? 57'h0 :
			(dbl ? 57'h1 : 57'h1_0000_0000));
		if (t[56]) return packF(s, e + 8'h01, fpmsu_pkg::MANT_ONE);
		else return packF(s, e, t[55:0]);
	endfunction

	function automatic logic [6:0] lzc(input logic [63:0] v);
		logic [6:0] n;
		logic       found;
		n = 7'h40;
		found = 1'b0;
		for (int i = 63; i >= 0; i--) begin
			if (!found && v[i]) begin
				n = 7'(63 - i);
				found = 1'b1;
			end
		end
		return n;
	endfunction

	// ********************************************************
	// Declarations
	// ********************************************************
	fpmsu_pkg::fpmsu_state_t state_r;
	logic [63:0]  src_r;
	logic [15:0]  fstat_r;
	logic [2:0]   op_r;
	logic [1:0]   acc_r;
	logic [63:0]  fracRes_r, intRes_r;
	logic [3:0]   cc_r;
	logic         trapSticky_r, trapReq_r;
	logic [1:0]   cause_r;
	logic         awHeld_r, wHeld_r, bvalid_r, rvalid_r;
	logic [7:0]   awAddr_r;
	logic [31:0]  wData_r, rdata_r, rdMux;
	logic [3:0]   wStrb_r;
	logic [1:0]   bresp_r, rresp_r;
	logic         doWrite, cmdGo, flagClr;
	logic         memWe;
	logic [1:0]   memWaddr;
	logic [63:0]  memWdata, accD;
	logic         dbl, chop, overflow_trap_enable, underflow_trap_enable, undefined_value_trap_enable, sgn, hi, isZero, ovf, unf, undefTrap;
	logic         trapNow, vFlag;
	logic [1:0]   trapKind;
	logic [7:0]   eA, eB;
	logic [55:0]  mA, mB, intM;
	logic [111:0] full_product, nrm;
	logic [63:0]  w, f, fracRes, intRes;
	logic [6:0]   lz;
	logic signed [10:0] eP, kS, lim;
	logic signed [15:0] sv;

	// ********************************************************
	// AXI4-Lite slave
	// ********************************************************
	assign doWrite       = awHeld_r && wHeld_r && !bvalid_r;
	assign s_axi_awready = !awHeld_r && !bvalid_r;
	assign s_axi_wready  = !wHeld_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign cmdGo   = doWrite && awAddr_r == fpmsu_pkg::REG_CMD && wStrb_r[0]
		&& state_r == fpmsu_pkg::S_IDLE;
	assign flagClr = doWrite && awAddr_r == fpmsu_pkg::REG_FLAGS && wStrb_r[1]
		&& wData_r[fpmsu_pkg::FLAG_TRAP];

	// Address and data are latched apart so either may arrive first
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r  <= 32'h0;
			wStrb_r  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_r <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer with a slave error
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= fpmsu_pkg::RESP_OKAY;
		end else if (doWrite) begin
			bvalid_r <= 1'b1;
			bresp_r  <= isMapped(awAddr_r) ? fpmsu_pkg::RESP_OKAY : fpmsu_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read decode; stored status hides bits that cannot be recovered
	always_comb begin
		rdMux = 32'h0;
		if (s_axi_araddr == fpmsu_pkg::REG_CMD) rdMux = {31'h0, state_r != fpmsu_pkg::S_IDLE};
		else if (s_axi_araddr == fpmsu_pkg::REG_FSTAT)
			rdMux = {16'h0, fstat_r & fpmsu_pkg::FS_STORE_MASK};
		else if (s_axi_araddr == fpmsu_pkg::REG_SRCLO) rdMux = src_r[31:0];
		else if (s_axi_araddr == fpmsu_pkg::REG_SRCHI) rdMux = src_r[63:32];
		else if (s_axi_araddr == fpmsu_pkg::REG_FLAGS)
			rdMux = {21'h0, cause_r, trapSticky_r, 4'h0, cc_r};
		else if (s_axi_araddr == fpmsu_pkg::REG_FRACLO) rdMux = fracRes_r[31:0];
		else if (s_axi_araddr == fpmsu_pkg::REG_FRACHI) rdMux = fracRes_r[63:32];
		else if (s_axi_araddr == fpmsu_pkg::REG_INTLO) rdMux = intRes_r[31:0];
		else if (s_axi_araddr == fpmsu_pkg::REG_INTHI) rdMux = intRes_r[63:32];
	end

	// Read data answer one cycle after the address is taken
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= fpmsu_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rdMux;
			rresp_r  <= isMapped(s_axi_araddr) ? fpmsu_pkg::RESP_OKAY : fpmsu_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Source operand, byte lanes honoured
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			src_r <= 64'h0;
		end else if (doWrite && awAddr_r == fpmsu_pkg::REG_SRCLO) begin
			src_r[31:0] <= merge(src_r[31:0], wData_r, wStrb_r);
		end else if (doWrite && awAddr_r == fpmsu_pkg::REG_SRCHI) begin
			src_r[63:32] <= merge(src_r[63:32], wData_r, wStrb_r);
		end
	end

	// ********************************************************
	// Sequencer and accumulator file
	// ********************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= fpmsu_pkg::S_IDLE;
			op_r    <= 3'h0;
			acc_r   <= 2'h0;
		end else begin
			case (state_r)
				fpmsu_pkg::S_IDLE: begin
					if (cmdGo) begin
						op_r    <= wData_r[2:0];
						acc_r   <= wData_r[fpmsu_pkg::CMD_ACC_LSB +: 2];
						state_r <= fpmsu_pkg::S_READ;
					end
				end
				fpmsu_pkg::S_READ: state_r <= fpmsu_pkg::S_EXEC;
				fpmsu_pkg::S_EXEC: begin
					// Integer part only for an even accumulator
					if (op_r == fpmsu_pkg::OP_SPLIT && !acc_r[0] && !undefTrap)
						state_r <= fpmsu_pkg::S_WRINT;
					else
						state_r <= fpmsu_pkg::S_IDLE;
				end
				default: state_r <= fpmsu_pkg::S_IDLE;
			endcase
		end
	end

	// Fraction (or plain result) first, integer part in the next cycle
	assign memWe    = (state_r == fpmsu_pkg::S_EXEC && op_r != fpmsu_pkg::OP_STLD
		&& !undefTrap) || state_r == fpmsu_pkg::S_WRINT;
	assign memWaddr = state_r == fpmsu_pkg::S_WRINT ? {acc_r[1], 1'b1} : acc_r;
	assign memWdata = state_r == fpmsu_pkg::S_WRINT ? intRes_r : fracRes;

	fpmsu_acc_mem u_mem (
		.core_clk (core_clk),
		.we       (memWe),
		.waddr    (memWaddr),
		.wdata    (memWdata),
		.raddr    (acc_r),
		.rdata    (accD)
	);

	// ********************************************************
	// Datapath
	// ********************************************************
	assign dbl  = fstat_r[fpmsu_pkg::FS_DBL];
	assign chop = fstat_r[fpmsu_pkg::FS_CHOP];
	assign overflow_trap_enable  = fstat_r[fpmsu_pkg::FS_FIV];
	assign underflow_trap_enable  = fstat_r[fpmsu_pkg::FS_FIU];
	assign undefined_value_trap_enable = fstat_r[fpmsu_pkg::FS_UNDEFINED_VALUE_TRAP_ENABLE];
	assign eA   = accD[62:55];
	assign eB   = src_r[62:55];
	assign sgn  = accD[63] ^ src_r[63];
	assign mA   = dbl ? {1'b1, accD[54:0]} : {1'b1, accD[54:32], 32'h0};
	assign mB   = dbl ? {1'b1, src_r[54:0]} : {1'b1, src_r[54:32], 32'h0};
	assign full_product = mA * mB;
	assign hi   = full_product[111];
	assign nrm  = hi ? full_product : {full_product[110:0], 1'b0};
	// Double products are cut to 59 bits, so low fraction bits can be off
	assign w    = dbl ? (nrm[111:48] & fpmsu_pkg::W59_MASK) : nrm[111:48];
	assign eP   = 11'(eA) + 11'(eB) - 11'(fpmsu_pkg::EXP_BIAS) - 11'(!hi);
	assign kS   = eP - 11'(fpmsu_pkg::EXP_BIAS);
	assign lim  = dbl ? 11'(fpmsu_pkg::SIG_DOUBLE) : 11'(fpmsu_pkg::SIG_SINGLE);
	assign isZero = eA == 8'h00 || eB == 8'h00;
	assign ovf  = !isZero && eP > 11'sh0ff;
	assign unf  = !isZero && eP < 11'sh001;
	assign undefTrap = undefined_value_trap_enable && src_r[63] && eB == 8'h00 && (op_r == fpmsu_pkg::OP_SPLIT
		|| op_r == fpmsu_pkg::OP_MUL || op_r == fpmsu_pkg::OP_LOAD);
	assign intM = chopM(w, dbl) & ~(fpmsu_pkg::MANT_ALL >> kS[5:0]);
	assign f    = w << kS[5:0];
	assign lz   = lzc(f);
	assign sv   = src_r[15:0];

	// Result selection for every operation
	always_comb begin
		fracRes  = 64'h0;
		intRes   = 64'h0;
		trapKind = 2'h0;
		vFlag    = 1'b0;
		case (op_r)
			fpmsu_pkg::OP_SPLIT: begin
				vFlag = ovf;
				if (isZero) begin
					fracRes = 64'h0;
				end else if (ovf) begin
					if (overflow_trap_enable) begin
						intRes   = packF(sgn, eP[7:0], chopM(w, dbl));
						trapKind = fpmsu_pkg::TRAP_OVF;
					end
				end else if (unf) begin
					if (underflow_trap_enable) begin
						fracRes  = packR(sgn, 8'(eP + fpmsu_pkg::EXP_WRAP), w, dbl, chop);
						trapKind = fpmsu_pkg::TRAP_UNF;
					end
				end else if (kS > lim) begin // Scale above L: the value is at least two to the L, all integer
					intRes = packF(sgn, eP[7:0], chopM(w, dbl));
				end else if (kS >= 11'sh001) begin
					intRes = packF(sgn, eP[7:0], intM);
					if (f != 64'h0)
						fracRes = packR(sgn, fpmsu_pkg::EXP_BIAS - {1'b0, lz}, f << lz, dbl, chop);
				end else begin
					fracRes = packR(sgn, eP[7:0], w, dbl, chop);
				end
			end
			fpmsu_pkg::OP_MUL: begin
				vFlag = ovf;
				if (isZero || (ovf && !overflow_trap_enable) || (unf && !underflow_trap_enable)) begin
					fracRes = 64'h0;
				end else begin
					fracRes  = packR(sgn, eP[7:0], w, dbl, chop);
					trapKind = ovf ? fpmsu_pkg::TRAP_OVF : (unf ? fpmsu_pkg::TRAP_UNF : 2'h0);
				end
			end
			fpmsu_pkg::OP_EXPLD: begin
				vFlag   = sv > 16'sh007f;
				fracRes = {accD[63], 8'(sv) + fpmsu_pkg::EXP_BIAS, accD[54:0]};
				if (sv > 16'sh007f) begin
					if (overflow_trap_enable) trapKind = fpmsu_pkg::TRAP_OVF;
					else fracRes = 64'h0;
				end else if (sv < -16'sh007f) begin
					if (underflow_trap_enable) trapKind = fpmsu_pkg::TRAP_UNF;
					else fracRes = 64'h0;
				end
			end
			fpmsu_pkg::OP_LOAD: fracRes = dbl ? src_r : {src_r[63:32], 32'h0};
			default: fracRes = 64'h0;
		endcase
		if (undefTrap) trapKind = fpmsu_pkg::TRAP_UNDEF;
	end

	assign trapNow = state_r == fpmsu_pkg::S_EXEC && trapKind != 2'h0;

	// Results, condition flags and status load
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fracRes_r <= 64'h0;
			intRes_r  <= 64'h0;
			cc_r      <= 4'h0;
			fstat_r   <= fpmsu_pkg::FSTAT_RST;
		end else if (state_r == fpmsu_pkg::S_EXEC && !undefTrap) begin
			if (op_r == fpmsu_pkg::OP_STLD) begin
				fstat_r <= src_r[15:0];
			end else begin
				fracRes_r <= fracRes;
				intRes_r  <= intRes;
				cc_r      <= {fracRes[63], fracRes[62:55] == 8'h00, vFlag, 1'b0};
			end
		end
	end

	// Trap report; a new trap wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			trapSticky_r <= 1'b0;
			trapReq_r    <= 1'b0;
			cause_r      <= 2'h0;
		end else begin
			trapReq_r <= trapNow;
			if (trapNow) begin
				trapSticky_r <= 1'b1;
				cause_r      <= trapKind;
			end else if (flagClr) begin
				trapSticky_r <= 1'b0;
			end
		end
	end
	assign trapReq   = trapReq_r;
	assign trapCause = cause_r;

	// ********************************************************
	// Assertions
	// ********************************************************
	property p_int_pair;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && op_r == fpmsu_pkg::OP_SPLIT && !acc_r[0] && !undefTrap
		|=> memWe && memWaddr == {acc_r[1], 1'b1} && memWdata == $past(intRes);
	endproperty
	a_int_pair: assert property (p_int_pair) else $error("integer part not paired");

	property p_odd_only;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && acc_r[0] |=> state_r == fpmsu_pkg::S_IDLE && !memWe;
	endproperty
	a_odd_only: assert property (p_odd_only) else $error("odd accumulator got integer");

	property p_sign_pair;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && op_r == fpmsu_pkg::OP_SPLIT && !ovf && !unf
		&& !isZero && kS >= 11'sh001 && kS <= lim && f != 64'h0 |-> fracRes[63] == intRes[63];
	endproperty
	a_sign_pair: assert property (p_sign_pair) else $error("part signs differ");

	property p_ovf_off;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && op_r == fpmsu_pkg::OP_SPLIT && ovf && !overflow_trap_enable
		|-> fracRes == 64'h0 && intRes == 64'h0 && !trapNow;
	endproperty
	a_ovf_off: assert property (p_ovf_off) else $error("untrapped overflow not zero");

	property p_unf_on;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && op_r == fpmsu_pkg::OP_SPLIT && unf && underflow_trap_enable && !undefTrap
		|-> intRes == 64'h0 ##1 trapReq && trapCause == fpmsu_pkg::TRAP_UNF;
	endproperty
	a_unf_on: assert property (p_unf_on) else $error("underflow trap missing");

	property p_undef;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && undefTrap
		|-> !memWe ##1 trapReq && state_r == fpmsu_pkg::S_IDLE;
	endproperty
	a_undef: assert property (p_undef) else $error("negative zero source executed");

	property p_stld;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && op_r == fpmsu_pkg::OP_STLD |=> fstat_r == $past(src_r[15:0]);
	endproperty
	a_stld: assert property (p_stld) else $error("status not loaded");

	property p_flags;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && op_r == fpmsu_pkg::OP_SPLIT && !undefTrap
		|=> cc_r[0] == 1'b0 && cc_r[1] == $past(ovf) && cc_r[3] == fracRes_r[63];
	endproperty
	a_flags: assert property (p_flags) else $error("split flags wrong");

	property p_mul_zero;
		@(posedge core_clk) disable iff (!arst_n)
		state_r == fpmsu_pkg::S_EXEC && op_r == fpmsu_pkg::OP_MUL && isZero && !undefTrap
		|-> memWe && memWdata == 64'h0;
	endproperty
	a_mul_zero: assert property (p_mul_zero) else $error("zero operand not exact zero");

	property p_cmd_busy;
		@(posedge core_clk) disable iff (!arst_n)
		cmdGo |=> state_r == fpmsu_pkg::S_READ ##1 state_r == fpmsu_pkg::S_EXEC;
	endproperty
	a_cmd_busy: assert property (p_cmd_busy) else $error("command sequence broken");
endmodule // fpmsu_core

// ==== hw/fpmsu_pkg.sv ====
// Constants, types and register map of the floating multiply-and-split unit.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package fpmsu_pkg;

	// ********************************************************
	// Register map and fields
	// ********************************************************
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_FSTAT  = 8'h04;
	localparam logic [7:0] REG_SRCLO  = 8'h08;
	localparam logic [7:0] REG_SRCHI  = 8'h0c;
	localparam logic [7:0] REG_FLAGS  = 8'h10;
	localparam logic [7:0] REG_FRACLO = 8'h14;
	localparam logic [7:0] REG_FRACHI = 8'h18;
	localparam logic [7:0] REG_INTLO  = 8'h1c;
	localparam logic [7:0] REG_INTHI  = 8'h20;
	localparam int unsigned CMD_ACC_LSB = 4;
	localparam int unsigned FLAG_TRAP   = 8;
	localparam int unsigned FLAG_CAUSE  = 9;
	// Status register control bits
	localparam int unsigned FS_CHOP = 5;
	localparam int unsigned FS_DBL  = 7;
	localparam int unsigned FS_FIV  = 9;
	localparam int unsigned FS_FIU  = 10;
	localparam int unsigned FS_UNDEFINED_VALUE_TRAP_ENABLE = 11;
	localparam logic [15:0] FS_STORE_MASK = 16'hcfef;
	localparam logic [15:0] FSTAT_RST     = 16'h0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ********************************************************
	// Number format
	// ********************************************************
	localparam logic [7:0]  EXP_BIAS = 8'h80;
	localparam logic [10:0] EXP_WRAP = 11'h100;
	localparam int unsigned SIG_SINGLE = 24;
	localparam int unsigned SIG_DOUBLE = 56;
	localparam logic [63:0] W59_MASK = 64'hffff_ffff_ffff_ffe0;
	localparam logic [55:0] MANT_ALL = 56'hff_ffff_ffff_ffff;
	localparam logic [55:0] MANT_ONE = 56'h80_0000_0000_0000;

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [2:0] {
		OP_SPLIT = 3'h0,
		OP_MUL   = 3'h1,
		OP_EXPLD = 3'h2,
		OP_LOAD  = 3'h3,
		OP_STLD  = 3'h4
	} fpmsu_op_t;
	typedef enum logic [1:0] {S_IDLE, S_READ, S_EXEC, S_WRINT} fpmsu_state_t;
	localparam logic [1:0] TRAP_UNDEF = 2'h1;
	localparam logic [1:0] TRAP_OVF   = 2'h2;
	localparam logic [1:0] TRAP_UNF   = 2'h3;

endpackage

// ==== hw/fpmsu_acc_mem.sv ====
// Floating accumulator file: four 64-bit words, one write port.
// Assumes the reader presents an address one cycle before using the data.
module fpmsu_acc_mem (
	input  wire logic        core_clk,
	input  wire logic        we,
	input  wire logic [1:0]  waddr,
	input  wire logic [63:0] wdata,
	input  wire logic [1:0]  raddr,
	output logic      [63:0] rdata
);
	logic [63:0] mem [4];

	// Storage has no reset; software loads accumulators before use
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port
	always_ff @(posedge core_clk) begin
		rdata <= mem[raddr];
	end
endmodule // fpmsu_acc_mem

// ==== tb/fpmsu_host.sv ====
// AXI4-Lite master standing in for the CPU side of the float unit.
// Assumes one clock; address and data may be taken in either order.
module fpmsu_host (
	input  wire logic        core_clk,
	output logic      [7:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [7:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Bus cycles
	// ****************
	// Idle bus from time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// Readies sampled mid-cycle, so the value seen is the one the next edge takes
	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end while (!tb);
	endtask
	// Read; no wait length is assumed, only the watchdog ends a hang
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic ta, tr;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end while (!tr);
	endtask
endmodule // fpmsu_host

// ==== tb/test_fp_multiply_split_unit.sv ====
// Self-checking bench of the float multiply-and-split unit, single mode.
// Assumes the unit's register map and a 25 MHz clock.
module test_fp_multiply_split_unit;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, trapCause, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, trapReq;
	int failures = 0, cmp_count = 0, trapCnt = 0;
	fpmsu_core DUT (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trapReq, .trapCause);
	fpmsu_host host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// Clock and trap pulse count; a stuck pulse would count more than once
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (trapReq === 1'b1) trapCnt <= trapCnt + 1;
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#400000;
		failures++;
		give_verdict();
	end
	// ****************
	// Helpers
	// ****************
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		host.rd(a, d, r);
		chk(nm, d, e);
	endtask
	// Source high word, command, then poll busy with a bound
	task op(input logic [31:0] hi, input logic [2:0] o, input logic [1:0] acc);
		int n;
		host.wr(fpmsu_pkg::REG_SRCHI, hi, r);
		host.wr(fpmsu_pkg::REG_CMD, {26'h0, acc, 1'b0, o}, r);
		n = 0;
		do begin
			host.rd(fpmsu_pkg::REG_CMD, d, r);
			n++;
		end while (d[0] !== 1'b0 && n < 50);
		chk("idle", {31'h0, d[0]}, 32'h0);
	endtask
	task give_verdict();
		$display("mismatches %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ****************
	// Tests
	// ****************
	initial begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		rdc("fstat", fpmsu_pkg::REG_FSTAT, 32'h0);
		chk("cause", {30'h0, trapCause}, 32'h0);
		op(32'h40c00000, fpmsu_pkg::OP_LOAD, 2'h0);
		op(32'h41200000, fpmsu_pkg::OP_SPLIT, 2'h0);
		rdc("frac", fpmsu_pkg::REG_FRACHI, 32'h40400000);
		rdc("int", fpmsu_pkg::REG_INTHI, 32'h41400000);
		rdc("flags", fpmsu_pkg::REG_FLAGS, 32'h0);
		op(32'h40800000, fpmsu_pkg::OP_MUL, 2'h1);
		rdc("acc1", fpmsu_pkg::REG_FRACHI, 32'h41400000);
		op(32'h41200000, fpmsu_pkg::OP_SPLIT, 2'h1);
		rdc("odd", fpmsu_pkg::REG_FRACHI, 32'h40000000);
		op(32'hc1200000, fpmsu_pkg::OP_SPLIT, 2'h0);
		rdc("nfrac", fpmsu_pkg::REG_FRACHI, 32'hc0600000);
		rdc("nint", fpmsu_pkg::REG_INTHI, 32'hc0800000);
		rdc("nflags", fpmsu_pkg::REG_FLAGS, 32'h8);
		host.wr(fpmsu_pkg::REG_SRCLO, 32'hffff, r);
		op(32'h0, fpmsu_pkg::OP_STLD, 2'h0);
		rdc("fsld", fpmsu_pkg::REG_FSTAT, 32'hcfef);
		host.wr(fpmsu_pkg::REG_SRCLO, 32'h0800, r);
		op(32'h0, fpmsu_pkg::OP_STLD, 2'h0);
		op(32'h80000000, fpmsu_pkg::OP_SPLIT, 2'h2);
		chk("cause", {30'h0, trapCause}, 32'h1);
		chk("traps", trapCnt, 32'h1);
		host.rd(fpmsu_pkg::REG_FLAGS, d, r);
		chk("sticky", d & 32'h700, 32'h300);
		host.rd(8'h40, d, r);
		chk("resp", {30'h0, r}, {30'h0, fpmsu_pkg::RESP_SLVERR});
		host.wr(8'h40, 32'h0, r);
		chk("wresp", {30'h0, r}, {30'h0, fpmsu_pkg::RESP_SLVERR});
		// Exponent load, then a sticky clear that keeps the cause
		host.wr(fpmsu_pkg::REG_SRCLO, 32'h3, r);
		chk("bresp", {30'h0, r}, {30'h0, fpmsu_pkg::RESP_OKAY});
		op(32'h0, fpmsu_pkg::OP_EXPLD, 2'h0);
		rdc("expld", fpmsu_pkg::REG_FRACHI, 32'hc1e00000);
		host.wr(fpmsu_pkg::REG_FLAGS, 32'h100, r);
		rdc("clr", fpmsu_pkg::REG_FLAGS, 32'h208);
		op(32'h0, fpmsu_pkg::OP_MUL, 2'h0);
		rdc("mulz", fpmsu_pkg::REG_FRACHI, 32'h0);
		rdc("zflag", fpmsu_pkg::REG_FLAGS, 32'h204);
		// Tiny operands underflow with the trap on: wrapped exponent, zero integer
		host.wr(fpmsu_pkg::REG_SRCLO, 32'h0400, r);
		op(32'h0, fpmsu_pkg::OP_STLD, 2'h0);
		op(32'h00c00000, fpmsu_pkg::OP_LOAD, 2'h2);
		op(32'h00c00000, fpmsu_pkg::OP_SPLIT, 2'h2);
		rdc("ufrac", fpmsu_pkg::REG_FRACHI, 32'h41100000);
		rdc("uint", fpmsu_pkg::REG_INTHI, 32'h0);
		chk("ucause", {30'h0, trapCause}, 32'h3);
		chk("utraps", trapCnt, 32'h2);
		// With traps off, huge and tiny products both give exact zeros
		host.wr(fpmsu_pkg::REG_SRCLO, 32'h0, r);
		op(32'h0, fpmsu_pkg::OP_STLD, 2'h0);
		op(32'h7fc00000, fpmsu_pkg::OP_LOAD, 2'h2);
		op(32'h7fc00000, fpmsu_pkg::OP_SPLIT, 2'h2);
		rdc("ofrac", fpmsu_pkg::REG_FRACHI, 32'h0);
		rdc("oint", fpmsu_pkg::REG_INTHI, 32'h0);
		rdc("oflags", fpmsu_pkg::REG_FLAGS, 32'h706);
		op(32'h00c00000, fpmsu_pkg::OP_LOAD, 2'h2);
		op(32'h00c00000, fpmsu_pkg::OP_SPLIT, 2'h2);
		rdc("zfrac", fpmsu_pkg::REG_FRACHI, 32'h0);
		chk("ztraps", trapCnt, 32'h2);
		give_verdict();
	end
endmodule // test_fp_multiply_split_unit
